// file: core/acc_conv_seq.sv
/*
  Conversion sequencer: times one conversion and latches the sample.
  Assumes the analog core holds sample_i valid at the end of a conversion.
*/
`timescale 1ns/10ps
module acc_conv_seq import acc_pkg::*; #(
  parameter int CONV_CYCLES = 23
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Control
  input wire logic start,
  input wire logic abort,
  // Analog side
  input wire acc_result_t sample_i,
  // Status
  output logic busy,
  output logic done,
  output acc_result_t result
);

  localparam int CW = $clog2(CONV_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CONV_CYCLES - 1);

  acc_state_e state_reg, state_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  acc_result_t result_reg;

  assign busy = state_reg == ACC_CONV;
  assign done = busy && cnt_reg == '0;
  assign result = result_reg;

  // Start wins over abort and over completion
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    if (start) begin
      state_next = ACC_CONV;
      cnt_next = LAST;
    end else if (abort || done) begin
      state_next = ACC_IDLE;
    end else if (busy) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ACC_IDLE;
      cnt_reg <= '0;
      result_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      if (done) begin
        result_reg <= sample_i;
      end
    end
  end

endmodule

// file: core/acc_irq.sv
/*
  Sticky event status with mask and one level interrupt.
  Assumes a read strobe of the status register lasts one cycle.
*/
`timescale 1ns/10ps
module acc_irq #(
  parameter int W = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Events and register access
  input wire logic [W-1:0] ev,
  input wire logic rd_clr,
  input wire logic wr_mask,
  input wire logic [W-1:0] mask_d,
  // Status
  output logic [W-1:0] status,
  output logic [W-1:0] mask,
  output logic irq
);

  logic [W-1:0] status_reg, mask_reg;
  wire [W-1:0] status_next = (status_reg & ~{W{rd_clr}}) | ev;

  assign status = status_reg;
  assign mask = mask_reg;
  assign irq = |(status_reg & mask_reg);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status_reg <= '0;
      mask_reg <= '0;
    end else begin
      status_reg <= status_next;
      if (wr_mask) begin
        mask_reg <= mask_d;
      end
    end
  end

endmodule

// file: core/acc_pkg.sv
/*
  Types of the converter control block.
  Assumes nothing of its surroundings.
*/
package acc_pkg;

  typedef logic [9:0] acc_result_t;

  typedef struct packed {
    logic done;
    logic irq_en;
    logic cont_en;
    logic [4:0] chan;
  } acc_sc_s;

  typedef enum logic [1:0] {
    ACC_IDLE = 2'b01,
    ACC_CONV = 2'b10
  } acc_state_e;

endpackage

// file: core/acc_regs.svh
/*
  Register indices, field positions, reset values and timing counts of
  the converter control block. Assumes inclusion by bare name.
*/
`ifndef ACC_REGS_SVH
`define ACC_REGS_SVH

// Register indices; byte address is four times the index
`define ACC_IDX_SC 6'h3C
`define ACC_IDX_HI 6'h3D
`define ACC_IDX_LO 6'h3E
`define ACC_IDX_CK 6'h3F
`define ACC_IDX_EVST 6'h30
`define ACC_IDX_EVMSK 6'h31

// Status/control fields
`define ACC_SC_DONE 7
`define ACC_SC_IRQEN 6
`define ACC_SC_CONT 5
`define ACC_SC_CHAN_HI 4
`define ACC_SC_RST 8'h1F

// Clock configuration fields
`define ACC_CK_ASYNC 0
`define ACC_CK_RST 8'h00

// Event status bits
`define ACC_EV_DONE 0
`define ACC_EV_STOP 1
`define ACC_EV_W 2

// Conversion length in bus clocks
`define ACC_CONV_CYCLES 23

`endif

// file: core/acc_top.sv
/*
  Converter control block: status/control, clock configuration and result
  registers behind a classic Wishbone slave, with conversion sequencing.
  Assumes one bus clock, synchronous pin inputs and an analog core that
  presents a sample on sample_i.
*/
// The Wishbone interface to the registers and the placing of the registers were left to the implementer.
// Contract
// - Any status/control write aborts and restarts conversion unless channel is all ones.
// - Status/control: done bit7, irq enable bit6, continuous bit5, channel 4:0; reset 0x1F.
// - Done flag is read-only, set by hardware at every conversion end.
// - Done flag clears on status/control write or low result read.
// - With irq enable set, each conversion end raises the interrupt request.
// - Interrupt request drops on result read or status/control write; irq_o stays high while any event status bit set in the mask stays set.
// - Continuous mode converts back to back, updating results each time.
// - Continuous stops on reset, clock config write, status write, unprotected stop.
// - After stop-mode halt, only a new status/control write restarts conversion.
// - Write with continuous set and valid channel aborts and starts continuous.
// - Result split: high holds bits 9:8 with zeros above, low bits 7:0.
`timescale 1ns/10ps
`include "acc_regs.svh"
module acc_top import acc_pkg::*; #(
  parameter int CONV_CYCLES = `ACC_CONV_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // System
  input wire logic stop_mode_i,
  output logic irq_o,
  // Analog core
  input wire acc_result_t sample_i,
  output logic [4:0] channel_o,
  output logic converting_o
);

  acc_sc_s sc_reg, sc_next;
  logic [7:0] ck_reg;
  logic cont_reg, cont_next;
  logic req_reg, req_next;
  logic stop_prev_reg;
  logic ack_reg;
  logic [31:0] dat_reg;
  logic conv_done, conv_busy;
  acc_result_t result;
  logic [`ACC_EV_W-1:0] ev_status, ev_mask;
  logic ev_irq;

  function automatic logic chan_off(input logic [4:0] c);
    return &c;
  endfunction

  // Bus decode
  wire bus_req = wb_cyc_i & wb_stb_i;
  wire bus_do = bus_req & ack_reg;
  wire [5:0] idx = wb_adr_i[7:2];
  wire hit_sc = idx == `ACC_IDX_SC;
  wire hit_hi = idx == `ACC_IDX_HI;
  wire hit_lo = idx == `ACC_IDX_LO;
  wire hit_ck = idx == `ACC_IDX_CK;
  wire hit_st = idx == `ACC_IDX_EVST;
  wire hit_mk = idx == `ACC_IDX_EVMSK;
  wire wr_en = bus_do & wb_we_i & wb_sel_i[0];
  wire rd_en = bus_do & ~wb_we_i;
  wire wr_sc = wr_en & hit_sc;
  wire wr_ck = wr_en & hit_ck;
  wire rd_lo = rd_en & hit_lo;
  wire rd_res = rd_en & (hit_lo | hit_hi);
  wire [7:0] wdat = wb_dat_i[7:0];
  wire w_off = chan_off(wdat[`ACC_SC_CHAN_HI:0]);

  // Sequencing
  wire stop_entry = stop_mode_i & ~stop_prev_reg & ~ck_reg[`ACC_CK_ASYNC];
  wire auto_start = conv_done & cont_reg & ~wr_sc & ~wr_ck & ~stop_entry;
  wire wr_start = wr_sc & ~w_off;
  wire conv_start = wr_start | auto_start;
  wire conv_abort = wr_sc | stop_entry;
  wire halt_ev = stop_entry & (cont_reg | conv_busy);

  // Read mux
  wire [7:0] rd_byte = hit_sc ? sc_reg :
    hit_hi ? {6'h00, result[9:8]} :
    hit_lo ? result[7:0] :
    hit_ck ? ck_reg :
    hit_st ? {{(8 - `ACC_EV_W){1'b0}}, ev_status} :
    hit_mk ? {{(8 - `ACC_EV_W){1'b0}}, ev_mask} : 8'h00;

  always_comb begin
    sc_next = sc_reg;
    if (wr_sc) begin
      sc_next = acc_sc_s'(wdat);
    end
    sc_next.done = conv_done | (sc_reg.done & ~wr_sc & ~rd_lo);
  end

  assign cont_next = wr_sc ? (wdat[`ACC_SC_CONT] & ~w_off) :
    (wr_ck | stop_entry) ? 1'b0 : cont_reg;
  assign req_next = (conv_done & sc_reg.irq_en) | (req_reg & ~wr_sc & ~rd_res);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sc_reg <= acc_sc_s'(`ACC_SC_RST);
      ck_reg <= `ACC_CK_RST;
      cont_reg <= 1'b0;
      req_reg <= 1'b0;
      stop_prev_reg <= 1'b0;
    end else begin
      sc_reg <= sc_next;
      cont_reg <= cont_next;
      req_reg <= req_next;
      stop_prev_reg <= stop_mode_i;
      if (wr_ck) begin
        ck_reg <= wdat;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= bus_req & ~ack_reg;
      if (bus_req & ~ack_reg) begin
        dat_reg <= {24'h00_0000, rd_byte};
      end
    end
  end

  acc_conv_seq #(
    .CONV_CYCLES(CONV_CYCLES)
  ) u_seq (
    .clk(clk),
    .arst_n(arst_n),
    .start(conv_start),
    .abort(conv_abort),
    .sample_i(sample_i),
    .busy(conv_busy),
    .done(conv_done),
    .result(result)
  );

  acc_irq #(
    .W(`ACC_EV_W)
  ) u_irq (
    .clk(clk),
    .arst_n(arst_n),
    .ev({halt_ev, conv_done}),
    .rd_clr(rd_en & hit_st),
    .wr_mask(wr_en & hit_mk),
    .mask_d(wdat[`ACC_EV_W-1:0]),
    .status(ev_status),
    .mask(ev_mask),
    .irq(ev_irq)
  );

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign irq_o = req_reg | ev_irq;
  assign channel_o = sc_reg.chan;
  assign converting_o = conv_busy;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  done_flag_set_a: assert property (
    conv_done |=> sc_reg.done
  ) else $error("done flag not set after conversion end");

  write_clears_a: assert property (
    (wr_sc || rd_lo) && !conv_done |=> !sc_reg.done
  ) else $error("done flag not cleared by write or low read");

  write_starts_a: assert property (
    wr_sc && !w_off |=> converting_o ##0 u_seq.cnt_reg == CONV_CYCLES - 1
  ) else $error("status write did not restart conversion");

  off_idle_a: assert property (
    wr_sc && w_off |=> !converting_o ##1 !converting_o
  ) else $error("converter started with channel all ones");

  irq_raise_a: assert property (
    conv_done && sc_reg.irq_en |=> irq_o && req_reg
  ) else $error("no interrupt at conversion end");

  irq_drop_a: assert property (
    (wr_sc || rd_res) && !conv_done |=> !req_reg
  ) else $error("interrupt request not dropped");

  cont_loop_a: assert property (
    conv_done && cont_reg && !wr_sc && !wr_ck && !stop_entry
      |=> converting_o && cont_reg
  ) else $error("continuous mode did not restart");

  cont_stop_a: assert property (
    (wr_ck || stop_entry) && !wr_sc |=> !cont_reg
  ) else $error("continuous mode not stopped");

  stop_stay_a: assert property (
    stop_entry && !wr_sc |=> !converting_o ##1 (!converting_o || $past(wr_sc))
  ) else $error("conversion resumed after stop without a write");

  cont_enter_a: assert property (
    wr_sc && wdat[`ACC_SC_CONT] && !w_off |=> cont_reg && converting_o
  ) else $error("continuous mode not entered on write");

  single_shot_a: assert property (
    conv_done && !cont_reg && !wr_sc |=> !converting_o && sc_reg.done
  ) else $error("single conversion did not idle");

  high_zero_a: assert property (
    wb_ack_o && hit_hi && !wb_we_i |-> wb_dat_o[31:2] == 30'h0000_0000
  ) else $error("high result carries upper bits");

  ack_pulse_a: assert property (
    wb_ack_o |=> !wb_ack_o
  ) else $error("ack held longer than one cycle");

  one_shot_c: cover property (
    wr_sc && !wdat[`ACC_SC_CONT] && !w_off ##[1:40] conv_done
  );

  cont_two_c: cover property (
    cont_reg && conv_done ##[1:40] conv_done
  );

  stop_halt_c: cover property (
    cont_reg && stop_entry
  );

  irq_read_c: cover property (
    req_reg ##[1:20] rd_res
  );

endmodule

// file: sim/adc_conversion_control_test.sv
/*
  Self-checking bench of the converter control block.
  Assumes the block answers each Wishbone request with a registered ack.
*/
`timescale 1ns/10ps
module adc_conversion_control_test import acc_pkg::*;;
  localparam int CONV = 8;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [31:0] dat_o;
  logic [31:0] rd;
  logic ack;
  logic stop = 1'b0;
  logic irq;
  logic busy;
  logic [4:0] chan;
  acc_result_t sample = 10'h000;
  int err_total = 0;
  int n_checks = 0;
  logic [5:0] r_idx [7] = '{6'h3C, 6'h3D, 6'h3E, 6'h3F, 6'h30, 6'h31, 6'h10};
  logic [7:0] r_val [7] = '{8'h1F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  always #12.5 clk = ~clk;

  acc_top #(.CONV_CYCLES(CONV)) dut (.clk(clk), .arst_n(arst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .stop_mode_i(stop), .irq_o(irq),
    .sample_i(sample), .channel_o(chan), .converting_o(busy));

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One classic cycle; read data taken at the ack edge, returns mid-cycle
  task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'h1;
    adr <= {idx, 2'b00};
    dat_i <= {24'h00_0000, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      summarize();
    end
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(negedge clk);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 100) begin
      @(negedge clk);
      n++;
    end
    if (n >= 100) begin
      err_total++;
      summarize();
    end
  endtask

  task automatic idle_for(input int k);
    repeat (k) @(negedge clk);
  endtask

  initial begin
    idle_for(4);
    chk(8'(chan), 8'h1F);
    chk(8'(irq), 8'h00);
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, r_idx[i], 8'h00);
      chk(rd[7:0], r_val[i]);
    end
    // Single conversion with interrupt; done bit written high is ignored
    @(posedge clk);
    sample <= 10'h2A5;
    bus(1'b1, 6'h3C, 8'hC3);
    chk(8'(busy), 8'h01);
    chk(8'(chan), 8'h03);
    bus(1'b0, 6'h3C, 8'h00);
    chk(rd[7:0], 8'h43);
    wait_idle();
    idle_for(CONV);
    chk(8'(busy), 8'h00);
    chk(8'(irq), 8'h01);
    bus(1'b0, 6'h3C, 8'h00);
    chk(rd[7:0], 8'hC3);
    bus(1'b0, 6'h3D, 8'h00);
    chk(rd[7:0], 8'h02);
    idle_for(1);
    chk(8'(irq), 8'h00);
    bus(1'b0, 6'h3E, 8'h00);
    chk(rd[7:0], 8'hA5);
    bus(1'b0, 6'h3C, 8'h00);
    chk(rd[7:0], 8'h43);
    // Interrupt disabled; sticky event read clears
    bus(1'b1, 6'h3C, 8'h05);
    wait_idle();
    idle_for(2);
    chk(8'(irq), 8'h00);
    bus(1'b0, 6'h30, 8'h00);
    chk(rd[7:0], 8'h01);
    bus(1'b0, 6'h30, 8'h00);
    chk(rd[7:0], 8'h00);
    // Abort by the off setting
    bus(1'b1, 6'h3C, 8'h05);
    bus(1'b1, 6'h3C, 8'h1F);
    idle_for(CONV);
    chk(8'(busy), 8'h00);
    bus(1'b0, 6'h3C, 8'h00);
    chk(rd[7:0], 8'h1F);
    // Continuous run, stopped by a clock config write
    @(posedge clk);
    sample <= 10'h155;
    bus(1'b1, 6'h3C, 8'h25);
    idle_for(3 * CONV);
    chk(8'(busy), 8'h01);
    @(posedge clk);
    sample <= 10'h0AA;
    idle_for(2 * CONV + 2);
    bus(1'b0, 6'h3E, 8'h00);
    chk(rd[7:0], 8'hAA);
    bus(1'b1, 6'h3F, 8'h00);
    wait_idle();
    idle_for(CONV);
    chk(8'(busy), 8'h00);
    // Stop entry halts, no restart; masked halt event raises irq
    bus(1'b1, 6'h31, 8'h02);
    bus(1'b1, 6'h3C, 8'h25);
    @(posedge clk);
    stop <= 1'b1;
    idle_for(3);
    chk(8'(busy), 8'h00);
    chk(8'(irq), 8'h01);
    @(posedge clk);
    stop <= 1'b0;
    idle_for(3 * CONV);
    chk(8'(busy), 8'h00);
    bus(1'b0, 6'h30, 8'h00);
    chk(rd[7:0] & 8'h02, 8'h02);
    idle_for(1);
    chk(8'(irq), 8'h00);
    // Async clock kept: stop entry leaves continuous running
    bus(1'b1, 6'h3F, 8'h01);
    bus(1'b1, 6'h3C, 8'h25);
    @(posedge clk);
    stop <= 1'b1;
    idle_for(3 * CONV);
    chk(8'(busy), 8'h01);
    @(posedge clk);
    stop <= 1'b0;
    bus(1'b1, 6'h3C, 8'h1F);
    idle_for(CONV);
    chk(8'(busy), 8'h00);
    // Reset in mid-run stops continuous conversion
    bus(1'b1, 6'h3C, 8'h65);
    @(posedge clk);
    arst_n <= 1'b0;
    idle_for(2);
    chk(8'(busy), 8'h00);
    chk(8'(chan), 8'h1F);
    chk(8'(irq), 8'h00);
    @(posedge clk);
    arst_n <= 1'b1;
    idle_for(2 * CONV);
    chk(8'(busy), 8'h00);
    bus(1'b0, 6'h3C, 8'h00);
    chk(rd[7:0], 8'h1F);
    bus(1'b0, 6'h3F, 8'h00);
    chk(rd[7:0], 8'h00);
    summarize();
  end
endmodule
